// [rtl/ppm_top.sv]
// Chosen here: the AHB-Lite register port and the placing of the registers.
module ppm_top #(
  parameter int LP_CYCLES = ppm_pkg::LP_CYCLES_DFLT, // link pulse period
  parameter int LP_LONG = ppm_pkg::LP_LONG_FACTOR    // stretch factor
) (
  input wire logic clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // line status from the receiver, asynchronous
  input wire logic link_up,
  // power control to the transceiver
  output ppm_pkg::ppm_pwr_s pwr_en,
  output ppm_pkg::ppm_state_e pm_state,
  output logic link_pulse,
  output logic soft_reset
);
  import ppm_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ppm_cfg_s cfg;            // configuration bits
  logic link_meta;          // synchroniser first stage
  logic link_sync;          // synchronised link status
  logic wr_pend;            // write data phase pending
  logic [4:0] wr_idx;       // index of pending write
  logic addr_ok;            // address phase hits a word slot
  logic [4:0] addr_idx;     // index of current address phase
  logic take;               // address phase accepted
  logic [31:0] next_rdata;  // read word for current address
  ppm_state_e next_state;   // mode decided from config and line
  ppm_pwr_s next_pwr;       // enables decided from next_state
  logic [31:0] lp_count;    // link pulse interval counter
  logic [31:0] lp_limit;    // active interval length
  logic lp_run;             // pulses wanted in this mode
  logic swrst_hit;          // soft reset written this cycle

  // ----------------------------------------------------------------
  // link status synchroniser
  // ----------------------------------------------------------------
  // two flops; only the second stage feeds the mode decision
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_meta <= 1'b0;
      link_sync <= 1'b0;
    end
    else
    begin
      link_meta <= link_up;
      link_sync <= link_meta;
    end
  end

  // ----------------------------------------------------------------
  // ahb address phase
  // ----------------------------------------------------------------
  assign addr_idx = haddr[IDX_MSB:IDX_LSB];
  // upper bits and byte offset must be zero to hit a register
  assign addr_ok = (haddr[31:IDX_MSB+1] == '0) &&
                   (haddr[IDX_LSB-1:0] == '0);
  assign take = hsel && hready &&
                (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // latch writes for the data phase; unmapped writes are dropped
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_pend <= 1'b0;
      wr_idx <= '0;
    end
    else if (hready)
    begin
      wr_pend <= take && hwrite && addr_ok;
      wr_idx <= addr_idx;
    end
  end

  // zero wait state slave, always okay
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // reserved bits and unmapped words read zero; the soft reset bit
  // is self-clearing so it always reads zero
  always_comb
  begin
    next_rdata = '0;
    if (addr_ok)
    begin
      case (addr_idx)
        REG_BASIC_CTRL_IDX:
        begin
          next_rdata[BIT_AN_EN] = cfg.an_en;
          next_rdata[BIT_PDOWN] = cfg.pdown;
        end
        REG_PLL_CTRL_IDX:
          next_rdata[BIT_PLL_AUTO_OFF] = cfg.pll_auto_off;
        REG_OSC_CTRL_IDX:
          next_rdata[BIT_SLOW_OSC] = cfg.slow_osc;
        REG_ENERGY_DETECT_POWERDOWN_CTRL_IDX:
          next_rdata[BIT_ENERGY_DETECT_POWERDOWN_DIS] = cfg.energy_detect_powerdown_dis;
        REG_PHY_CTRL2_IDX:
          next_rdata[BIT_PSAVE_EN] = cfg.psave_en;
        REG_PM_OPTION_IDX:
          next_rdata[BIT_LP_LONG] = cfg.lp_long;
        REG_PM_STATUS_IDX:
        begin
          // live mode and line status for software
          next_rdata[5:0] = pm_state;
          next_rdata[BIT_ST_LINK] = link_sync;
        end
        default:
          next_rdata = '0;
      endcase
    end
  end

  // read data captured at the address phase, stands in the data phase
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hrdata <= '0;
    else if (take && !hwrite)
      hrdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  assign swrst_hit = wr_pend && (wr_idx == REG_BASIC_CTRL_IDX) &&
                     hwdata[BIT_SOFT_RESET];

  // this process runs on clk in every mode, so a write always gets
  // through even while the pll or reference input is stopped
  always_ff @(posedge clk or negedge reset_n) // RULE_14
  begin
    if (!reset_n)
      cfg <= CFG_RESET; // RULE_03 RULE_07
    else if (swrst_hit)
      // a soft reset returns every bit to its power-up value, which
      // finishes the host's exit sequence from the lowest state
      cfg <= CFG_RESET; // RULE_13
    else if (wr_pend)
    begin
      case (wr_idx)
        REG_BASIC_CTRL_IDX:
        begin
          cfg.an_en <= hwdata[BIT_AN_EN];
          cfg.pdown <= hwdata[BIT_PDOWN]; // RULE_08 RULE_10
        end
        REG_PLL_CTRL_IDX:
          cfg.pll_auto_off <= hwdata[BIT_PLL_AUTO_OFF]; // RULE_05
        REG_OSC_CTRL_IDX:
          cfg.slow_osc <= hwdata[BIT_SLOW_OSC]; // RULE_11
        REG_ENERGY_DETECT_POWERDOWN_CTRL_IDX:
          cfg.energy_detect_powerdown_dis <= hwdata[BIT_ENERGY_DETECT_POWERDOWN_DIS]; // RULE_04
        REG_PHY_CTRL2_IDX:
          cfg.psave_en <= hwdata[BIT_PSAVE_EN]; // RULE_01
        REG_PM_OPTION_IDX:
          cfg.lp_long <= hwdata[BIT_LP_LONG];
        default:
          cfg <= cfg; // read-only or unmapped
      endcase
    end
  end

  // soft reset strobe to the rest of the transceiver
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      soft_reset <= 1'b0;
    else
      soft_reset <= swrst_hit; // RULE_13
  end

  // ----------------------------------------------------------------
  // mode decision
  // ----------------------------------------------------------------
  // power-down outranks the cable-driven modes; the energy-detect
  // mode outranks power-saving; it saves more only with the pll auto-off bit set
  always_comb
  begin
    next_state = ST_NORMAL;
    if (cfg.pdown)
    begin
      if (cfg.slow_osc)
        next_state = ST_PDOWN_SLOW; // RULE_12
      else
        next_state = ST_PDOWN; // RULE_08
    end
    else if (cfg.an_en && !link_sync)
    begin
      if (!cfg.energy_detect_powerdown_dis)
      begin
        if (cfg.pll_auto_off)
          next_state = ST_ENERGY_DETECT_POWERDOWN_PLL; // RULE_05
        else
          next_state = ST_ENERGY_DETECT_POWERDOWN; // RULE_04
      end
      else if (cfg.psave_en)
        next_state = ST_PSAVE; // RULE_01
    end
  end

  // enables for the chosen mode
  always_comb
  begin
    next_pwr = '0;
    // oscillator source follows its bit in every mode
    next_pwr.slow_sel = cfg.slow_osc; // RULE_11
    next_pwr.ref_in = !cfg.slow_osc; // RULE_11
    case (next_state)
      ST_NORMAL:
      begin
        next_pwr.rx_blocks = 1'b1;
        next_pwr.tx = 1'b1;
        next_pwr.energy = 1'b1;
        next_pwr.pll = 1'b1;
      end
      ST_PSAVE:
      begin
        // receive side dark, keep what listens for a cable
        next_pwr.tx = 1'b1; // RULE_02
        next_pwr.energy = 1'b1; // RULE_02
        next_pwr.pll = 1'b1; // RULE_02
      end
      ST_ENERGY_DETECT_POWERDOWN:
      begin
        next_pwr.tx = 1'b1;
        next_pwr.energy = 1'b1;
        next_pwr.pll = 1'b1;
      end
      ST_ENERGY_DETECT_POWERDOWN_PLL:
      begin
        // pll off; only transmitter and energy detect stay
        next_pwr.tx = 1'b1; // RULE_05
        next_pwr.energy = 1'b1; // RULE_05
      end
      ST_PDOWN:
        next_pwr.rx_blocks = 1'b0; // RULE_09
      ST_PDOWN_SLOW:
      begin
        // lowest state: nothing but the register slave runs
        next_pwr.slow_sel = 1'b1; // RULE_12
        next_pwr.ref_in = 1'b0; // RULE_12
      end
      default:
        next_pwr = '0;
    endcase
  end

  // registered mode and enables
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pm_state <= ST_NORMAL;
      pwr_en <= '0;
    end
    else
    begin
      pm_state <= next_state;
      pwr_en <= next_pwr; // RULE_02 RULE_09
    end
  end

  // ----------------------------------------------------------------
  // link pulse generator
  // ----------------------------------------------------------------
  // both energy-detect states send pulses so two sleeping ends can
  // still find each other; the long option trades wake latency for
  // power
  assign lp_run = (pm_state == ST_ENERGY_DETECT_POWERDOWN) ||
                  (pm_state == ST_ENERGY_DETECT_POWERDOWN_PLL); // RULE_06
  assign lp_limit = cfg.lp_long ? 32'(LP_CYCLES * LP_LONG) :
                                  32'(LP_CYCLES);

  // interval counter restarts whenever pulses are not wanted
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      lp_count <= '0;
    else if (!lp_run || lp_count >= lp_limit - 32'h1)
      lp_count <= '0;
    else
      lp_count <= lp_count + 32'h1;
  end

  // one-cycle pulse at the end of each interval
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      link_pulse <= 1'b0;
    else
      link_pulse <= lp_run && (lp_count == lp_limit - 32'h1); // RULE_06
  end

endmodule

// [pkg/ppm_pkg.sv]
// Function
// RULE_01: power-saving bit enters mode when autoneg, no link
// RULE_02: power-saving keeps only transmitter, energy detect, pll
// RULE_03: power-saving enable resets to disabled
// RULE_04: energy-detect powerdown enabled by writing zero
// RULE_05: pll auto-off bit stops pll in energy-detect
// RULE_06: energy-detect keeps sending periodic link pulses
// RULE_07: energy-detect disable bit resets to one
// RULE_08: power-down bit set enters power-down
// RULE_09: power-down keeps only management register access
// RULE_10: clearing power-down bit leaves power-down
// RULE_11: slow-oscillator bit swaps reference for on-chip oscillator
// RULE_12: slow oscillator plus power-down is lowest state
// RULE_13: host exits: clear slow, clear power-down, reset
// RULE_14: register logic stays clocked in every mode
package ppm_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_BASIC_CTRL_IDX = 5'h00;
  localparam logic [4:0] REG_PLL_CTRL_IDX = 5'h10;
  localparam logic [4:0] REG_OSC_CTRL_IDX = 5'h11;
  localparam logic [4:0] REG_PM_STATUS_IDX = 5'h14;
  localparam logic [4:0] REG_PM_OPTION_IDX = 5'h15;
  localparam logic [4:0] REG_ENERGY_DETECT_POWERDOWN_CTRL_IDX = 5'h18;
  localparam logic [4:0] REG_PHY_CTRL2_IDX = 5'h1f;

  // address decode: word index sits in haddr[6:2]
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 6;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_SOFT_RESET = 15;
  localparam int BIT_AN_EN = 12;
  localparam int BIT_PDOWN = 11;
  localparam int BIT_PLL_AUTO_OFF = 4;
  localparam int BIT_SLOW_OSC = 5;
  localparam int BIT_ENERGY_DETECT_POWERDOWN_DIS = 11;
  localparam int BIT_PSAVE_EN = 10;
  localparam int BIT_LP_LONG = 0;
  localparam int BIT_ST_LINK = 8;

  // ----------------------------------------------------------------
  // software-visible configuration
  // ----------------------------------------------------------------
  typedef struct packed {
    logic an_en;        // auto-negotiation enable
    logic pdown;        // power-down request
    logic pll_auto_off; // pll off while energy-detect powerdown
    logic slow_osc;     // run from on-chip slow oscillator
    logic energy_detect_powerdown_dis;     // active-low energy_detect_powerdown enable
    logic psave_en;     // power-saving enable
    logic lp_long;      // stretched link pulse interval
  } ppm_cfg_s;

  // reset values
  localparam ppm_cfg_s CFG_RESET = '{
    an_en: 1'b1, pdown: 1'b0, pll_auto_off: 1'b0, slow_osc: 1'b0,
    energy_detect_powerdown_dis: 1'b1, psave_en: 1'b0, lp_long: 1'b0};

  // block enables handed to the analog side
  typedef struct packed {
    logic rx_blocks; // every transceiver block but the three below
    logic tx;        // transmitter
    logic energy;    // energy detect
    logic pll;       // pll
    logic slow_sel;  // slow oscillator selected
    logic ref_in;    // ref_crystal_input connected
  } ppm_pwr_s;

  // power modes, one-hot
  typedef enum logic [5:0] {
    ST_NORMAL     = 6'h01,
    ST_PSAVE      = 6'h02,
    ST_ENERGY_DETECT_POWERDOWN       = 6'h04,
    ST_ENERGY_DETECT_POWERDOWN_PLL   = 6'h08,
    ST_PDOWN      = 6'h10,
    ST_PDOWN_SLOW = 6'h20
  } ppm_state_e;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int LP_INTERVAL_MS = 16;
  localparam int LP_CYCLES_DFLT = LP_INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
  localparam int LP_LONG_FACTOR = 4;

  // ahb
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

endpackage

// [verif/ppm_top_monitor.sv]
// ----------------------------------------------------------------
// power-mode checker, sees only top-level ports
// ----------------------------------------------------------------
module ppm_top_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic link_pulse,
  input wire ppm_pkg::ppm_state_e pm_state,
  input wire ppm_pkg::ppm_pwr_s pwr_en,
  input wire logic soft_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  import ppm_pkg::*;
  logic wr0; // data phase of a write to the control word
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // remember an accepted write to index 0 for its data phase
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      wr0 <= 1'b0;
    else
      wr0 <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0;
  AST_PULSE_ENERGY_DETECT_POWERDOWN: assert property (link_pulse |->
    $past(pm_state) inside {ST_ENERGY_DETECT_POWERDOWN, ST_ENERGY_DETECT_POWERDOWN_PLL}) else $error("stray pulse");
  AST_PSAVE_PWR: assert property (pm_state == ST_PSAVE |->
    pwr_en[5:2] == 4'h7) else $error("power-saving enables wrong");
  AST_PLL_OFF: assert property (pm_state == ST_ENERGY_DETECT_POWERDOWN_PLL |->
    pwr_en[5:2] == 4'h6) else $error("pll not off");
  AST_PDOWN_PWR: assert property (pm_state == ST_PDOWN |->
    pwr_en == 6'b000001) else $error("power-down enables wrong");
  AST_SLOW_PWR: assert property (pm_state == ST_PDOWN_SLOW |->
    pwr_en == 6'b000010) else $error("lowest state enables wrong");
  AST_PD_ENTRY: assert property (wr0 && hwdata[11] && !hwdata[15] |->
    ##2 pm_state inside {ST_PDOWN, ST_PDOWN_SLOW}) else $error("no pdown");
  AST_PD_EXIT: assert property (wr0 && !hwdata[11] |->
    ##2 !(pm_state inside {ST_PDOWN, ST_PDOWN_SLOW})) else $error("stuck");
  AST_SRST_CAUSE: assert property (wr0 && hwdata[15] |=>
    soft_reset ##1 !soft_reset) else $error("soft reset pulse wrong");
  AST_SRST_MODE: assert property (soft_reset |=>
    pm_state == ST_NORMAL && pwr_en == 6'b111101) else $error("not normal");
endmodule
bind ppm_top ppm_top_monitor mon_u (.clk, .reset_n, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .link_pulse, .pm_state, .pwr_en, .soft_reset);

// [verif/ppm_line_model.sv]
// ----------------------------------------------------------------
// cable and link partner seen from the transceiver
// ----------------------------------------------------------------
module ppm_line_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cable, // bench plugs or pulls the cable
  input wire logic link_pulse,
  output logic link_up,
  output int gap // cycles between the last two pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt; // cycles since last pulse
  // partner reports link one cycle after the cable goes in
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      link_up <= 1'b0;
    else
      link_up <= cable;
  // measure pulse spacing; bench compares it with the period
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      cnt <= 0;
      gap <= 0;
    end
    else if (link_pulse)
    begin
      gap <= cnt;
      cnt <= 1;
    end
    else
      cnt <= cnt + 1;
endmodule

// [verif/ppm_top_bench.sv]
module ppm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ppm_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic cable = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2; // whole words only
  logic hreadyout;
  logic hresp; // slave response, must stay okay
  logic link_up;
  logic link_pulse;
  logic soft_reset;
  ppm_pwr_s pwr_en;
  ppm_state_e pm_state;
  int n_mismatch = 0;
  int n_checks = 0;
  int gap;
  always #5 clk = ~clk;
  // short pulse period keeps the run brief
  ppm_top #(.LP_CYCLES(20), .LP_LONG(2)) dut_u (.clk, .reset_n, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata,
    .hreadyout, .hresp, .link_up, .pwr_en, .pm_state, .link_pulse,
    .soft_reset);
  ppm_line_model line_u (.clk, .reset_n, .cable, .link_pulse, .link_up,
    .gap);
  task end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait for hready; a hang ends the run
  task wait_rdy();
    for (int k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (hreadyout === 1'b1)
        return;
    end
    n_mismatch++;
    end_of_test();
  endtask
  // one single ahb transfer, address phase then data phase
  task bus(input logic w, input logic [4:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {25'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task rdc(input logic [4:0] idx, input logic [31:0] e, input string n);
    bus(1'b0, idx, 32'h0);
    chk(n, e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // mode and enables settle a fixed number of edges after the cause
  task mode(input ppm_state_e s, input logic [5:0] p, input int n);
    repeat (n) @(posedge clk);
    #1;
    chk("pm_state", 32'(s), 32'(pm_state));
    chk("pwr_en", 32'(p), 32'(pwr_en));
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdc(REG_BASIC_CTRL_IDX, 32'h1000, "ctrl");
    rdc(REG_PLL_CTRL_IDX, 32'h0, "pll");
    rdc(REG_OSC_CTRL_IDX, 32'h0, "osc");
    rdc(REG_ENERGY_DETECT_POWERDOWN_CTRL_IDX, 32'h800, "energy_detect_powerdown");
    rdc(REG_PHY_CTRL2_IDX, 32'h0, "ctrl2");
    mode(ST_NORMAL, 6'b111101, 0);
    bus(1'b1, 5'h05, 32'hffffffff);
    rdc(5'h05, 32'h0, "unmapped");
    bus(1'b1, REG_PHY_CTRL2_IDX, 32'h400);
    mode(ST_PSAVE, 6'b011101, 2);
    rdc(REG_PM_STATUS_IDX, 32'h2, "status psave");
    @(posedge clk);
    cable <= 1'b1;
    mode(ST_NORMAL, 6'b111101, 6);
    @(posedge clk);
    cable <= 1'b0;
    mode(ST_PSAVE, 6'b011101, 6);
    bus(1'b1, REG_ENERGY_DETECT_POWERDOWN_CTRL_IDX, 32'h0);
    mode(ST_ENERGY_DETECT_POWERDOWN, 6'b011101, 2);
    repeat (50) @(posedge clk);
    chk("pulse gap", 32'd20, gap);
    bus(1'b1, REG_PM_OPTION_IDX, 32'h1);
    repeat (100) @(posedge clk);
    chk("long gap", 32'd40, gap);
    bus(1'b1, REG_PLL_CTRL_IDX, 32'h10);
    mode(ST_ENERGY_DETECT_POWERDOWN_PLL, 6'b011001, 2);
    bus(1'b1, REG_BASIC_CTRL_IDX, 32'h1800);
    mode(ST_PDOWN, 6'b000001, 2);
    bus(1'b1, REG_OSC_CTRL_IDX, 32'h20);
    mode(ST_PDOWN_SLOW, 6'b000010, 2);
    rdc(REG_BASIC_CTRL_IDX, 32'h1800, "ctrl in pdown");
    // host leaves the lowest state in the required order
    bus(1'b1, REG_OSC_CTRL_IDX, 32'h0);
    mode(ST_PDOWN, 6'b000001, 2);
    bus(1'b1, REG_BASIC_CTRL_IDX, 32'h1000);
    mode(ST_ENERGY_DETECT_POWERDOWN_PLL, 6'b011001, 2);
    bus(1'b1, REG_BASIC_CTRL_IDX, 32'h9000);
    #1;
    chk("soft_reset", 32'h1, 32'(soft_reset));
    mode(ST_NORMAL, 6'b111101, 1);
    rdc(REG_ENERGY_DETECT_POWERDOWN_CTRL_IDX, 32'h800, "energy_detect_powerdown after reset");
    end_of_test();
  end
endmodule
